// ===== logic/edpc_energy_detect.sv
// edpc_energy_detect: energy detect power control with its management register slave.
// assumes: mdc, mdio_in and energy inputs are synchronous to clock; mdc is well below clock/2.
`timescale 1ns/1ns

module edpc_energy_detect #(
    parameter logic [4:0] PHY_ADDR         = 5'h01,
    parameter int         PULSE_GAP_CYCLES = 4
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       clock_enable,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe_n,
    input  wire logic [3:0] rx_energy_count,
    input  wire logic       rx_energy_seen,
    output logic            line_power_up,
    output logic            energy_pulse
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    edpc_pkg::edpc_md_t   md_state, next_md_state;
    logic        [5:0]    ones, next_ones;
    logic        [4:0]    cnt, next_cnt;
    logic        [11:0]   hdr, next_hdr;
    logic                 rd_op, next_rd_op;
    logic                 hit, next_hit;
    logic        [15:0]   shreg, next_shreg;
    logic                 next_mdio_out, next_mdio_oe_n;
    logic                 mdc_q;
    logic                 wr_commit, next_wr_commit;
    logic        [15:0]   wr_data, next_wr_data;

    edpc_pkg::edpc_ctrl_t ctrl, next_ctrl;
    logic                 manual_power_transition, next_manual;
    edpc_pkg::edpc_pwr_t  ed_state, next_ed_state;
    logic        [2:0]    pulse_left, next_pulse_left;
    logic        [7:0]    gap, next_gap;
    logic                 next_line_power_up, next_energy_pulse;

    logic                 mdc_rise;
    logic        [12:0]   full_hdr;
    logic        [15:0]   rd_word;

    assign mdc_rise = mdc && !mdc_q;
    assign full_hdr = {hdr, mdio_in};

    always_comb begin
        rd_word = 16'h0000;
        rd_word[edpc_pkg::BIT_ENABLE] = ctrl.enable;
        rd_word[edpc_pkg::BIT_AUTO_UP] = ctrl.auto_up;
        rd_word[edpc_pkg::BIT_AUTO_DOWN] = ctrl.auto_down;
        rd_word[edpc_pkg::BIT_MANUAL] = manual_power_transition;
        rd_word[edpc_pkg::BIT_BURST_DIS] = ctrl.burst_dis;
        rd_word[edpc_pkg::BIT_PWR_STATE] = line_power_up;
        rd_word[edpc_pkg::THR_MSB:edpc_pkg::THR_LSB] = ctrl.threshold;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // management frame slave

    always_comb begin
        next_md_state  = md_state;
        next_ones      = ones;
        next_cnt       = cnt;
        next_hdr       = hdr;
        next_rd_op     = rd_op;
        next_hit       = hit;
        next_shreg     = shreg;
        next_mdio_out  = mdio_out;
        next_mdio_oe_n = mdio_oe_n;
        next_wr_commit = 1'b0;
        next_wr_data   = wr_data;
        if (mdc_rise) begin
            case (md_state)
                edpc_pkg::EDPC_MD_PRE: begin
                    if (mdio_in) begin
                        if (ones != edpc_pkg::PREAMBLE_ONES) begin
                            next_ones = ones + 6'h01;
                        end
                    end else if (ones == edpc_pkg::PREAMBLE_ONES) begin
                        next_md_state = edpc_pkg::EDPC_MD_HDR;
                        next_cnt      = 5'h00;
                    end else begin
                        next_ones = 6'h00;
                    end
                end
                edpc_pkg::EDPC_MD_HDR: begin
                    next_hdr = full_hdr[11:0];
                    next_cnt = cnt + 5'h01;
                    // start bit one, op, phy and register: thirteen rises, cnt 0 to HDR_LAST
                    if (cnt == edpc_pkg::HDR_LAST) begin
                        next_cnt   = 5'h00;
                        next_rd_op = full_hdr[11:10] == edpc_pkg::OP_READ;
                        next_hit   = full_hdr[4:0] == edpc_pkg::REG_ADDR;
                        // frames for other addresses are dropped so another device may answer
                        if (full_hdr[12] && full_hdr[9:5] == PHY_ADDR &&
                            (full_hdr[11:10] == edpc_pkg::OP_READ || full_hdr[11:10] == edpc_pkg::OP_WRITE)) begin
                            next_md_state = edpc_pkg::EDPC_MD_TA;
                        end else begin
                            next_md_state = edpc_pkg::EDPC_MD_PRE;
                            next_ones     = 6'h00;
                        end
                    end
                end
                edpc_pkg::EDPC_MD_TA: begin
                    next_cnt = cnt + 5'h01;
                    if (cnt != 5'h00) begin
                        next_md_state = edpc_pkg::EDPC_MD_DATA;
                        next_cnt      = 5'h00;
                        if (rd_op) begin
                            next_mdio_out = rd_word[15];
                            next_shreg    = {rd_word[14:0], 1'b0};
                        end
                    end else if (rd_op && hit) begin
                        next_mdio_oe_n = 1'b0;
                        next_mdio_out  = 1'b0;
                    end
                end
                default: begin
                    next_cnt = cnt + 5'h01;
                    if (rd_op) begin
                        next_mdio_out = shreg[15];
                        next_shreg    = {shreg[14:0], 1'b0};
                    end else begin
                        next_shreg = {shreg[14:0], mdio_in};
                    end
                    if (cnt == edpc_pkg::DATA_LAST) begin
                        next_md_state  = edpc_pkg::EDPC_MD_PRE;
                        next_ones      = 6'h00;
                        next_mdio_oe_n = 1'b1;
                        next_wr_commit = !rd_op && hit;
                        next_wr_data   = {shreg[14:0], mdio_in};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            md_state  <= edpc_pkg::EDPC_MD_PRE;
            ones      <= 6'h00;
            cnt       <= 5'h00;
            hdr       <= 12'h000;
            rd_op     <= 1'b0;
            hit       <= 1'b0;
            shreg     <= 16'h0000;
            mdio_out  <= 1'b0;
            mdio_oe_n <= 1'b1;
            mdc_q     <= 1'b0;
            wr_commit <= 1'b0;
            wr_data   <= 16'h0000;
        end else if (clock_enable) begin
            md_state  <= next_md_state;
            ones      <= next_ones;
            cnt       <= next_cnt;
            hdr       <= next_hdr;
            rd_op     <= next_rd_op;
            hit       <= next_hit;
            shreg     <= next_shreg;
            mdio_out  <= next_mdio_out;
            mdio_oe_n <= next_mdio_oe_n;
            mdc_q     <= mdc;
            wr_commit <= next_wr_commit;
            wr_data   <= next_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // energy detect power control

    always_comb begin
        next_ctrl         = ctrl;
        next_manual       = 1'b0;
        next_ed_state     = ed_state;
        next_pulse_left   = pulse_left;
        next_gap          = gap;
        next_energy_pulse = 1'b0;
        if (wr_commit) begin
            next_ctrl.enable    = wr_data[edpc_pkg::BIT_ENABLE];
            next_ctrl.auto_up   = wr_data[edpc_pkg::BIT_AUTO_UP];
            next_ctrl.auto_down = wr_data[edpc_pkg::BIT_AUTO_DOWN];
            next_ctrl.burst_dis = wr_data[edpc_pkg::BIT_BURST_DIS];
            next_ctrl.threshold = wr_data[edpc_pkg::THR_MSB:edpc_pkg::THR_LSB];
            next_manual = wr_data[edpc_pkg::BIT_MANUAL];
        end
        // disabled keeps the line side powered
        if (!ctrl.enable) begin
            next_ed_state   = edpc_pkg::EDPC_UP;
            next_pulse_left = 3'h0;
        end else begin
            case (ed_state)
                edpc_pkg::EDPC_DOWN: begin
                    if (manual_power_transition || (ctrl.auto_up && rx_energy_count >= ctrl.threshold)) begin
                        next_ed_state = edpc_pkg::EDPC_UP;
                        next_pulse_left = ctrl.burst_dis ? edpc_pkg::SINGLE_PULSE : edpc_pkg::BURST_PULSES;
                        next_gap        = 8'h00;
                    end
                end
                default: begin
                    if (manual_power_transition || (ctrl.auto_down && !rx_energy_seen)) begin
                        next_ed_state   = edpc_pkg::EDPC_DOWN;
                        next_pulse_left = 3'h0;
                    end else if (pulse_left != 3'h0) begin
                        if (gap == 8'h00) begin
                            next_energy_pulse = 1'b1;
                            next_pulse_left   = pulse_left - 3'h1;
                            next_gap          = 8'(PULSE_GAP_CYCLES);
                        end else begin
                            next_gap = gap - 8'h01;
                        end
                    end
                end
            endcase
        end
        next_line_power_up = next_ed_state == edpc_pkg::EDPC_UP;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl                    <= '{edpc_pkg::RST_ENABLE, edpc_pkg::RST_AUTO_UP, edpc_pkg::RST_AUTO_DOWN,
                                         edpc_pkg::RST_BURST_DIS, edpc_pkg::RST_THRESHOLD};
            manual_power_transition <= 1'b0;
            ed_state                <= edpc_pkg::EDPC_UP;
            pulse_left              <= 3'h0;
            gap                     <= 8'h00;
            line_power_up           <= 1'b1;
            energy_pulse            <= 1'b0;
        end else if (clock_enable) begin
            ctrl                    <= next_ctrl;
            manual_power_transition <= next_manual;
            ed_state                <= next_ed_state;
            pulse_left              <= next_pulse_left;
            gap                     <= next_gap;
            line_power_up           <= next_line_power_up;
            energy_pulse            <= next_energy_pulse;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_disabled_stays_up: assert property (@(posedge clock) disable iff (reset)
        clock_enable && !ctrl.enable |=> line_power_up) else $error("disabled block powered down");

    a_threshold_powers_up: assert property (@(posedge clock) disable iff (reset)
        clock_enable && ctrl.enable && ctrl.auto_up && ed_state == edpc_pkg::EDPC_DOWN &&
        rx_energy_count >= ctrl.threshold |=> line_power_up) else $error("threshold reached without power-up");

    a_no_energy_down: assert property (@(posedge clock) disable iff (reset)
        clock_enable && ctrl.enable && ctrl.auto_down && ed_state == edpc_pkg::EDPC_UP && !rx_energy_seen
        |=> !line_power_up) else $error("no energy without power-down");

    a_manual_toggles: assert property (@(posedge clock) disable iff (reset)
        clock_enable && ctrl.enable && manual_power_transition
        |=> line_power_up != $past(line_power_up) && !manual_power_transition) else $error("manual bit did not toggle");

    a_status_readback: assert property (@(posedge clock) disable iff (reset)
        rd_word[edpc_pkg::BIT_PWR_STATE] == (ed_state == edpc_pkg::EDPC_UP)) else $error("power state bit wrong");

    a_burst_length: assert property (@(posedge clock) disable iff (reset)
        $rose(line_power_up) && $past(ctrl.enable)
        |-> pulse_left == ($past(ctrl.burst_dis) ? edpc_pkg::SINGLE_PULSE : edpc_pkg::BURST_PULSES))
        else $error("wrong pulse count at power-up");

    a_write_lands: assert property (@(posedge clock) disable iff (reset)
        clock_enable && wr_commit |=> ctrl.threshold == $past(wr_data[3:0]) &&
        ctrl.enable == $past(wr_data[edpc_pkg::BIT_ENABLE])) else $error("write not stored");

    a_release_idle: assert property (@(posedge clock) disable iff (reset)
        md_state == edpc_pkg::EDPC_MD_PRE || md_state == edpc_pkg::EDPC_MD_HDR |-> mdio_oe_n)
        else $error("mdio driven outside read data");

endmodule // edpc_energy_detect

// ===== logic/edpc_pkg.sv
// edpc_pkg: constants and types for the energy detect power control block.
// assumes: one 16-bit control word reached over the two-wire management interface.
package edpc_pkg;

    // management frame fields
    localparam logic [4:0] REG_ADDR      = 5'h1d;
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [4:0] HDR_LAST      = 5'h0c;
    localparam logic [4:0] DATA_LAST     = 5'h0f;

    // control word field positions
    localparam int BIT_ENABLE    = 15;
    localparam int BIT_AUTO_UP   = 14;
    localparam int BIT_AUTO_DOWN = 13;
    localparam int BIT_MANUAL    = 12;
    localparam int BIT_BURST_DIS = 11;
    localparam int BIT_PWR_STATE = 10;
    localparam int THR_MSB       = 3;
    localparam int THR_LSB       = 0;

    // reset values
    localparam logic       RST_ENABLE    = 1'b0;
    localparam logic       RST_AUTO_UP   = 1'b1;
    localparam logic       RST_AUTO_DOWN = 1'b1;
    localparam logic       RST_BURST_DIS = 1'b0;
    localparam logic [3:0] RST_THRESHOLD = 4'h1;

    // pulses sent at each power-up from the down state while enabled; the power-up on disable sends none
    localparam logic [2:0] BURST_PULSES = 3'h4;
    localparam logic [2:0] SINGLE_PULSE = 3'h1;

    typedef struct packed {
        logic       enable;
        logic       auto_up;
        logic       auto_down;
        logic       burst_dis;
        logic [3:0] threshold;
    } edpc_ctrl_t;

    typedef enum logic {EDPC_DOWN, EDPC_UP} edpc_pwr_t;

    typedef enum logic [1:0] {EDPC_MD_PRE, EDPC_MD_HDR, EDPC_MD_TA, EDPC_MD_DATA} edpc_md_t;

endpackage

// ===== tb/testbench.sv
// testbench: self-checking bench for the energy detect power control block.
// assumes: the bench is the management master and the line side; the mdio wire idles high.
`timescale 1ns/1ns

module testbench;
    localparam logic [4:0] PHY = 5'h01;

    logic        clock           = 1'b0;
    logic        reset           = 1'b1;
    logic        clock_enable    = 1'b1;
    logic        mdc             = 1'b0;
    logic        md_val          = 1'b1;
    logic        md_drv          = 1'b1;
    logic [3:0]  rx_energy_count = 4'h0;
    logic        rx_energy_seen  = 1'b1;
    logic        mdio_out;
    logic        mdio_oe_n;
    logic        line_power_up;
    logic        energy_pulse;
    logic        mdio_wire;
    int          errors          = 0;
    int          checks          = 0;
    int          oe_lows         = 0;
    int          lows;
    logic [15:0] rd_q[$];
    logic [2:0]  pulse_q[$];
    logic [3:0]  thr;
    logic [15:0] base;

    // released wire floats to the pull-up level
    assign mdio_wire = (mdio_oe_n === 1'b0) ? mdio_out : (md_drv ? md_val : 1'b1);

    edpc_energy_detect #(
        .PHY_ADDR         (PHY),
        .PULSE_GAP_CYCLES (4)
    ) i_edpc_energy_detect (
        .clock           (clock),
        .reset           (reset),
        .clock_enable    (clock_enable),
        .mdc             (mdc),
        .mdio_in         (mdio_wire),
        .mdio_out        (mdio_out),
        .mdio_oe_n       (mdio_oe_n),
        .rx_energy_count (rx_energy_count),
        .rx_energy_seen  (rx_energy_seen),
        .line_power_up   (line_power_up),
        .energy_pulse    (energy_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 clock = ~clock;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic test_done(input string name);
        $display("test %s done, errors so far %0d", name, errors);
    endtask

    // one full frame, mdc period of seven clocks; master lets go from turnaround on reads
    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
        logic [63:0] bits;
        bits = {32'hffff_ffff, 2'b01, op, PHY, ra, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            @(posedge clock);
            mdc    <= 1'b0;
            md_val <= bits[i];
            md_drv <= !(op == edpc_pkg::OP_READ && i < 18);
            repeat (3) @(posedge clock);
            mdc <= 1'b1;
            repeat (3) @(posedge clock);
        end
        @(posedge clock);
        mdc    <= 1'b0;
        md_drv <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    task automatic read_reg(input logic [15:0] exp);
        rd_q.push_back(exp);
        frame(edpc_pkg::OP_READ, edpc_pkg::REG_ADDR, 16'hffff);
    endtask

    task automatic write_reg(input logic [4:0] ra, input logic [15:0] wd);
        frame(edpc_pkg::OP_WRITE, ra, wd);
    endtask

    task automatic power_is(input logic exp);
        repeat (8) @(posedge clock);
        check("line power", {15'h0000, exp}, {15'h0000, line_power_up});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // read word monitor: skip the turnaround rise, then shift sixteen bits
    initial begin
        logic [15:0] word;
        forever begin
            @(negedge mdio_oe_n);
            oe_lows++;
            @(posedge mdc);
            for (int i = 0; i < 16; i++) begin
                @(posedge mdc);
                word = {word[14:0], mdio_out};
            end
            check("read word", (rd_q.size() > 0) ? rd_q.pop_front() : 16'hxxxx, word);
        end
    end

    // pulse monitor: a rise with nothing queued must send no pulse at all
    initial begin
        int         n;
        logic [2:0] exp;
        forever begin
            @(posedge line_power_up);
            if (!reset) begin
                n = 0;
                repeat (30) @(posedge clock) if (energy_pulse === 1'b1) n++;
                exp = (pulse_q.size() > 0) ? pulse_q.pop_front() : 3'h0;
                check("pulse count", {13'h0000, exp}, 16'(n));
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hf8b2_4613));
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        read_reg(16'h6401);
        test_done("reset values");

        write_reg(edpc_pkg::REG_ADDR, 16'he001);
        read_reg(16'he401);
        @(posedge clock);
        rx_energy_seen <= 1'b0;
        power_is(1'b0);
        read_reg(16'he001);
        test_done("auto power-down");

        thr = 4'($urandom_range(15, 2));
        write_reg(edpc_pkg::REG_ADDR, 16'he000 | thr);
        @(posedge clock);
        rx_energy_seen  <= 1'b1;
        rx_energy_count <= thr - 4'h1;
        power_is(1'b0);
        clock_enable    <= 1'b0;
        rx_energy_count <= thr;
        power_is(1'b0);
        pulse_q.push_back(edpc_pkg::BURST_PULSES);
        clock_enable <= 1'b1;
        power_is(1'b1);
        repeat (30) @(posedge clock);
        test_done("threshold power-up");

        // automatic paths off so only the manual bit can move the state
        base = 16'h9800 | thr;
        write_reg(edpc_pkg::REG_ADDR, base);
        power_is(1'b0);
        read_reg(16'h8800 | thr);
        pulse_q.push_back(edpc_pkg::SINGLE_PULSE);
        write_reg(edpc_pkg::REG_ADDR, base);
        power_is(1'b1);
        // auto power-down deselected: losing energy must not power down
        rx_energy_seen <= 1'b0;
        power_is(1'b1);
        test_done("manual transitions");

        write_reg(5'h1c, 16'h0000);
        lows = oe_lows;
        frame(edpc_pkg::OP_READ, 5'h1c, 16'hffff);
        check("unmapped drive", 16'(lows), 16'(oe_lows));
        read_reg(16'h8c00 | thr);
        test_done("unmapped register");

        write_reg(edpc_pkg::REG_ADDR, base);
        power_is(1'b0);
        write_reg(edpc_pkg::REG_ADDR, 16'h0000);
        power_is(1'b1);
        read_reg(16'h0400);
        test_done("disable");
        repeat (40) @(posedge clock);
        complete_run();
    end
endmodule // testbench
